/* File: hdl/mcs_pkg.sv */
// Purpose: constants, types and state layout for the measure/scan command block
// Assumes: 10 MHz core clock, 32-bit AXI4-Lite register bus with 8-bit byte addresses
// Notes: result slots are indexed by the measurement element code
package mcs_pkg;

  localparam longint CLK_HZ = 64'd10_000_000;
  localparam longint DWELL_NS = 64'd2_500_000;
  // least time, rounded up to whole cycles
  localparam longint DWELL_CYC_DEF = (DWELL_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000;

  // register byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_OWN_ADDR = 8'h04;
  localparam logic [7:0] ADDR_FAULT_SETUP = 8'h08;
  localparam logic [7:0] ADDR_THRESH = 8'h0c;
  localparam logic [7:0] ADDR_INTERVAL = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] IDX_SCAN_COUNT = 8'h16;
  localparam logic [7:0] ADDR_SCAN_COUNT = {IDX_SCAN_COUNT[5:0], 2'b00};
  localparam logic [7:0] ADDR_RESULT_BASE = 8'h80;

  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SFX_LSB = 8;
  localparam int CMD_ADDR_LSB = 16;
  localparam logic [3:0] STACK_ADDR_ALL = 4'hf;

  // status register fields
  localparam int STS_BUSY = 0;
  localparam int STS_SCAN = 1;
  localparam int STS_BIAS = 2;
  localparam int STS_FAULT_LSB = 4;

  // reset values
  localparam logic [3:0] SCAN_CNT_RST = 4'h0;
  localparam logic [3:0] TCE_RST = 4'h0;

  // measurement element codes
  localparam logic [5:0] SFX_VBAT = 6'h00;
  localparam logic [5:0] SFX_CELL12 = 6'h0c;
  localparam logic [5:0] SFX_INT_TEMP = 6'h10;
  localparam logic [5:0] SFX_EXT1 = 6'h11;
  localparam logic [5:0] SFX_EXT4 = 6'h14;
  localparam logic [5:0] SFX_REF_RAW = 6'h15;
  localparam logic [5:0] SFX_LOOPBACK = 6'h17;
  localparam int NUM_RES = 24;
  localparam logic [2:0] SEQ_LAST = 3'h6;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_MEASURE = 3'h1,
    OP_SCAN_TEMPS = 3'h2,
    OP_SCAN_ALL = 3'h3,
    OP_SCAN_CONT = 3'h4,
    OP_SCAN_INHIBIT = 3'h5
  } mcs_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DWELL = 2'b01,
    ST_CONV = 2'b11,
    ST_WAIT = 2'b10
  } mcs_fsm_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } mcs_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mcs_axi_rsp_t;

  typedef struct packed {
    logic start;
    logic [5:0] sel;
  } mcs_adc_req_t;

  typedef struct packed {
    logic done;
    logic [13:0] data;
  } mcs_adc_rsp_t;

  typedef struct packed {
    mcs_axi_rsp_t axi;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    mcs_fsm_t fsm;
    logic op_meas;
    logic [5:0] cur_code;
    logic [2:0] step;
    logic [31:0] dwell_cnt;
    logic scan_flag;
    logic [31:0] ivl_cnt;
    logic [31:0] interval;
    logic [3:0] own_addr;
    logic [3:0] tce;
    logic [13:0] thresh;
    logic [3:0] fault;
    logic [3:0] scan_cnt;
    logic bias;
    mcs_adc_req_t adc;
    logic [NUM_RES-1:0][13:0] res;
  } mcs_state_t;

endpackage

/* File: hdl/mcs_measure_scan.sv */
// Purpose: measure/scan command handling, receipt counter and temperature scan sequencer
// Assumes: converter is same-clock logic answering start with one done pulse plus data
// Notes: commands arrive as writes to the command register; results land in local slots
//
// What this block does
// - scan inhibit clears continuous flag, stops scanning
// - own-address measure bumps counter, starts measurement of a listed code
// - measure carries six-bit element suffix, decoded here
// - code zero pack, one-twelve cells
// - 0x10 internal, 0x11-0x14 external, 0x15 reference
// - convert once, store locally, return to standby
// - four-bit counter readable at index 0x16
// - every addressed scan or measure except scan inhibit bumps counter
// - counter wraps to zero past fifteen
// - busy ignores new measure or single scan, still counts; continuous and inhibit still set or clear the flag
// - each temperature input result stored fourteen bits
// - bias on, settle dwell, then convert inputs
// - bias off after all conversions finish
// - scan also samples internal, reference, loopback
// - enabled compare faults when value below threshold
// - disabled compare gives no fault; enables reset zero
// - scan continuous sets flag, repeats at interval
`timescale 1ns/1ps
`default_nettype none
module mcs_measure_scan
  import mcs_pkg::*;
#(
  parameter int unsigned DWELL_CYCLES = int'(DWELL_CYC_DEF)
) (
  input wire logic clk,                       // 10 MHz core clock
  input wire logic rst_n,                     // asynchronous reset, active low
  input wire mcs_axi_req_t axi_req,           // register bus from master
  output var mcs_axi_rsp_t axi_rsp,           // register bus to master
  output var mcs_adc_req_t adc_req,           // converter start and element select
  input wire mcs_adc_rsp_t adc_rsp,           // converter done pulse and result
  output var logic thermistor_bias_output     // switched thermistor bias enable
);

  // one flop copy of the whole state and its next value
  mcs_state_t s_r;
  mcs_state_t s_nxt;

  // byte-lane merge so a narrow write leaves the other lanes alone
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = d[8*i +: 8];
      end
    end
    return m;
  endfunction

  // order of a temperature scan: external inputs first, then the internal channels
  function automatic logic [5:0] seq_code(input logic [2:0] step);
    logic [5:0] c;
    case (step)
      3'h0, 3'h1, 3'h2, 3'h3: c = SFX_EXT1 + {3'h0, step};
      3'h4: c = SFX_INT_TEMP;
      3'h5: c = SFX_REF_RAW;
      default: c = SFX_LOOPBACK;
    endcase
    return c;
  endfunction

  // external inputs are the only ones that need bias or can raise a fault
  function automatic logic is_ext(input logic [5:0] c);
    return (c >= SFX_EXT1) && (c <= SFX_EXT4);
  endfunction

  // element codes with something behind them; the gaps are counted but start nothing
  function automatic logic listed(input logic [5:0] c);
    logic ok;
    ok = (c <= SFX_CELL12);
    ok = ok || ((c >= SFX_INT_TEMP) && (c <= SFX_REF_RAW));
    return ok;
  endfunction

  // one result word per element code, upwards from the result base
  function automatic logic slot_hit(input logic [7:0] a);
    return (a >= ADDR_RESULT_BASE) && (a[6:2] < 5'(NUM_RES));
  endfunction

  function automatic logic [31:0] status_word(input logic busy, input logic scan,
                                              input logic bias, input logic [3:0] fault);
    logic [31:0] w;
    w = 32'h0;
    w[STS_BUSY] = busy;
    w[STS_SCAN] = scan;
    w[STS_BIAS] = bias;
    w[STS_FAULT_LSB +: 4] = fault;
    return w;
  endfunction

  // a disabled compare never faults, whatever the value
  function automatic logic temp_fault(input logic [13:0] v, input logic [13:0] lim,
                                      input logic en);
    return en && (v < lim);
  endfunction

  // locals get a value at the top so no path leaves a latch
  always_comb begin
    logic [31:0] rd;
    logic [1:0] rresp;
    logic [31:0] wv;
    logic [4:0] ridx;
    logic [1:0] eidx;
    logic hit_own;
    logic hit_all;
    logic start_req;
    logic start_meas;
    logic [5:0] start_code;
    logic idle;
    rd = 32'h0;
    rresp = RESP_OKAY;
    wv = 32'h0;
    ridx = 5'h0;
    eidx = 2'h0;
    hit_own = 1'b0;
    hit_all = 1'b0;
    start_req = 1'b0;
    start_meas = 1'b0;
    start_code = SFX_VBAT;
    idle = (s_r.fsm == ST_IDLE);
    s_nxt = s_r;
    s_nxt.adc.start = 1'b0;

    // write address and data may arrive in either order
    if (s_r.axi.awready && axi_req.awvalid) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = axi_req.awaddr;
    end
    if (s_r.axi.wready && axi_req.wvalid) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = axi_req.wdata;
      s_nxt.w_strb = axi_req.wstrb;
    end
    if (s_r.axi.bvalid && axi_req.bready) begin
      s_nxt.axi.bvalid = 1'b0;
    end

    // a write executes once both halves are in and the last response was taken
    if (s_r.aw_have && s_r.w_have && !s_r.axi.bvalid) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.axi.bvalid = 1'b1;
      s_nxt.axi.bresp = RESP_OKAY;
      case (s_r.aw_addr)
        ADDR_CMD: begin
          wv = merge(32'h0, s_r.w_data, s_r.w_strb);
          hit_own = (wv[CMD_ADDR_LSB +: 4] == s_r.own_addr);
          hit_all = (wv[CMD_ADDR_LSB +: 4] == STACK_ADDR_ALL);
          start_code = wv[CMD_SFX_LSB +: 6];
          // the counter moves on every matching scan or measure except scan inhibit, busy or not,
          // so the host can confirm delivery by reading it before and after
          case (wv[CMD_OP_LSB +: 3])
            OP_MEASURE: begin
              if (hit_own) begin
                s_nxt.scan_cnt = s_r.scan_cnt + 4'h1;
                start_req = listed(start_code);
                start_meas = 1'b1;
              end
            end
            OP_SCAN_TEMPS, OP_SCAN_ALL: begin
              if (hit_own || hit_all) begin
                s_nxt.scan_cnt = s_r.scan_cnt + 4'h1;
                start_req = 1'b1;
              end
            end
            OP_SCAN_CONT: begin
              if (hit_own || hit_all) begin
                s_nxt.scan_cnt = s_r.scan_cnt + 4'h1;
                s_nxt.scan_flag = 1'b1;
                s_nxt.ivl_cnt = 32'h0;
              end
            end
            OP_SCAN_INHIBIT: begin
              if (hit_own || hit_all) begin
                // only the flag clears; a scan under way runs to its end
                s_nxt.scan_flag = 1'b0;
              end
            end
            default: begin
            end
          endcase
        end
        // stack address of this device; a measure answers only to it
        ADDR_OWN_ADDR: begin
          wv = merge({28'h0, s_r.own_addr}, s_r.w_data, s_r.w_strb);
          s_nxt.own_addr = wv[3:0];
        end
        ADDR_FAULT_SETUP: begin
          wv = merge({28'h0, s_r.tce}, s_r.w_data, s_r.w_strb);
          s_nxt.tce = wv[3:0];
        end
        ADDR_THRESH: begin
          wv = merge({18'h0, s_r.thresh}, s_r.w_data, s_r.w_strb);
          s_nxt.thresh = wv[13:0];
        end
        // interval counts clock cycles; zero gives back-to-back scans
        ADDR_INTERVAL: begin
          s_nxt.interval = merge(s_r.interval, s_r.w_data, s_r.w_strb);
        end
        ADDR_STATUS: begin
          // fault bits clear on writing one; a fault raised this cycle is set again below
          wv = merge(32'h0, s_r.w_data, s_r.w_strb);
          s_nxt.fault = s_r.fault & ~wv[STS_FAULT_LSB +: 4];
        end
        ADDR_SCAN_COUNT: begin
          // read-only counter: the write is answered and changes nothing
        end
        default: begin
          // result slots ignore writes; anything past the last slot is not decoded
          if (!slot_hit(s_r.aw_addr)) begin
            s_nxt.axi.bresp = RESP_DECERR;
          end
        end
      endcase
    end

    // a half already held blocks its channel until the write executes
    s_nxt.axi.awready = !s_nxt.aw_have;
    s_nxt.axi.wready = !s_nxt.w_have;

    // read channel: one read at a time, data one cycle after the address
    if (s_r.axi.rvalid && axi_req.rready) begin
      s_nxt.axi.rvalid = 1'b0;
    end
    if (s_r.axi.arready && axi_req.arvalid) begin
      ridx = axi_req.araddr[6:2];
      case (axi_req.araddr)
        ADDR_CMD: rd = 32'h0;
        ADDR_OWN_ADDR: rd = {28'h0, s_r.own_addr};
        ADDR_FAULT_SETUP: rd = {28'h0, s_r.tce};
        ADDR_THRESH: rd = {18'h0, s_r.thresh};
        ADDR_INTERVAL: rd = s_r.interval;
        ADDR_STATUS: rd = status_word(!idle, s_r.scan_flag, s_r.bias, s_r.fault);
        ADDR_SCAN_COUNT: rd = {28'h0, s_r.scan_cnt};
        default: begin
          // unmapped reads return zero with an error response
          if (slot_hit(axi_req.araddr)) begin
            rd = {18'h0, s_r.res[ridx]};
          end else begin
            rresp = RESP_DECERR;
          end
        end
      endcase
      s_nxt.axi.rvalid = 1'b1;
      s_nxt.axi.rdata = rd;
      s_nxt.axi.rresp = rresp;
    end
    s_nxt.axi.arready = !s_nxt.axi.rvalid;

    // continuous interval count; a due scan waits for the current operation to end
    if (s_r.scan_flag && (s_r.ivl_cnt != 32'h0)) begin
      s_nxt.ivl_cnt = s_r.ivl_cnt - 32'h1;
    end

    // operation sequencer: one conversion in flight at a time
    case (s_r.fsm)
      ST_IDLE: begin
        // a command start wins over a due continuous scan in the same cycle
        if (start_req) begin
          s_nxt.op_meas = start_meas;
          s_nxt.step = 3'h0;
          s_nxt.cur_code = start_meas ? start_code : seq_code(3'h0);
          // internal channels need no bias, so only external work waits the dwell
          if (!start_meas || is_ext(start_code)) begin
            s_nxt.bias = 1'b1;
            s_nxt.dwell_cnt = 32'(DWELL_CYCLES);
            s_nxt.fsm = ST_DWELL;
          end else begin
            s_nxt.fsm = ST_CONV;
          end
        end else if (s_r.scan_flag && (s_r.ivl_cnt == 32'h0)) begin
          s_nxt.ivl_cnt = s_r.interval;
          s_nxt.op_meas = 1'b0;
          s_nxt.step = 3'h0;
          s_nxt.cur_code = seq_code(3'h0);
          s_nxt.bias = 1'b1;
          s_nxt.dwell_cnt = 32'(DWELL_CYCLES);
          s_nxt.fsm = ST_DWELL;
        end
      end
      ST_DWELL: begin
        // settling time for the external networks before the first conversion
        if (s_r.dwell_cnt <= 32'h1) begin
          s_nxt.fsm = ST_CONV;
        end else begin
          s_nxt.dwell_cnt = s_r.dwell_cnt - 32'h1;
        end
      end
      ST_CONV: begin
        // start is one cycle wide; the select holds until the next start
        s_nxt.adc.start = 1'b1;
        s_nxt.adc.sel = s_r.cur_code;
        s_nxt.fsm = ST_WAIT;
      end
      ST_WAIT: begin
        // no timeout: a converter that never answers keeps the block busy until reset
        if (adc_rsp.done) begin
          s_nxt.res[s_r.cur_code[4:0]] = adc_rsp.data;
          eidx = 2'(s_r.cur_code - SFX_EXT1);
          if (is_ext(s_r.cur_code) && temp_fault(adc_rsp.data, s_r.thresh, s_r.tce[eidx])) begin
            s_nxt.fault[eidx] = 1'b1;
          end
          if (s_r.op_meas || (s_r.step == SEQ_LAST)) begin
            s_nxt.bias = 1'b0;
            s_nxt.fsm = ST_IDLE;
          end else begin
            s_nxt.step = s_r.step + 3'h1;
            s_nxt.cur_code = seq_code(s_r.step + 3'h1);
            s_nxt.fsm = ST_CONV;
          end
        end
      end
      default: begin
        // unused encodings fall back to standby with the bias off
        s_nxt.bias = 1'b0;
        s_nxt.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // every output is a flop of the state
  assign axi_rsp = s_r.axi;
  assign adc_req = s_r.adc;
  assign thermistor_bias_output = s_r.bias;

endmodule
`default_nettype wire

/* File: test/mcs_sva.sv */
// Purpose: bus and sequencer checks for mcs_measure_scan
// Assumes: bench runs the block with DWELL_CYCLES of 8
// Notes: bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module mcs_sva
  import mcs_pkg::*;
#(
  parameter int unsigned DWELL_CYCLES = 8
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire mcs_axi_req_t axi_req, // bus requests
  input wire mcs_axi_rsp_t axi_rsp, // bus answers
  input wire mcs_adc_req_t adc_req, // converter start
  input wire mcs_adc_rsp_t adc_rsp, // converter answer
  input wire logic thermistor_bias_output // bias switch
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic ext_sel = adc_req.sel inside {[SFX_EXT1:SFX_EXT4]};
  // quiet span sized for the simulation dwell of 8
  sequence s_settle;
    !adc_req.start [*8];
  endsequence
  sequence s_first_conv;
    ##[1:6] adc_req.start;
  endsequence
  chk_dwell_wait: assert property (
    $rose(thermistor_bias_output) |-> s_settle ##0 s_first_conv)
    else $error("conversion started inside the settling dwell");
  chk_bias_ext: assert property (adc_req.start && ext_sel |-> thermistor_bias_output)
    else $error("external input converted with bias off");
  chk_bias_off: assert property ($fell(thermistor_bias_output) |-> $past(adc_rsp.done))
    else $error("bias dropped without a finished conversion");
  chk_one_pulse: assert property (adc_req.start |=> !adc_req.start)
    else $error("converter start longer than one cycle");
  chk_sel_hold: assert property (adc_req.start |=> $stable(adc_req.sel))
    else $error("element select moved after start");
  chk_rd_lat: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  chk_wr_lat: assert property (
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |-> ##2 axi_rsp.bvalid)
    else $error("write answer late");
  chk_aw_block: assert property (axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready)
    else $error("write address channel open after acceptance");
  chk_r_block: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read channel open during response");
endmodule
bind mcs_measure_scan mcs_sva #(.DWELL_CYCLES(DWELL_CYCLES)) i_mcs_sva (
  .clk(clk), .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .adc_req(adc_req), .adc_rsp(adc_rsp),
  .thermistor_bias_output(thermistor_bias_output));
`default_nettype wire

/* File: test/mcs_adc_model.sv */
// Purpose: converter model answering start with one done pulse
// Assumes: same clock as the block
// Notes: result is the element code shifted up plus an offset
`timescale 1ns/1ps
`default_nettype none
module mcs_adc_model
  import mcs_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst_n, // reset, active low
  input wire mcs_adc_req_t adc_req, // start and select
  input wire logic slow, // long conversion when high
  input wire logic [13:0] ofs, // added to each result
  output var mcs_adc_rsp_t adc_rsp // done and data
);
  int cnt;
  logic [13:0] val;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      val <= '0;
      adc_rsp <= '0;
    end else begin
      // data toggles outside done so a stale read is caught
      adc_rsp.done <= (cnt == 1) && !adc_req.start;
      adc_rsp.data <= ((cnt == 1) && !adc_req.start) ? val : ~adc_rsp.data;
      if (adc_req.start) begin
        cnt <= slow ? 12 : 1;
        val <= {2'b00, adc_req.sel, 6'h00} + ofs;
      end else if (cnt == 1) begin
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Purpose: register-level test of mcs_measure_scan
// Assumes: converter model as far side, dwell shortened to 8
// Notes: expected results follow the model's code-shift pattern
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mcs_pkg::*;
  logic clk, rst_n, slow, bias;
  logic [13:0] ofs;
  mcs_axi_req_t req;
  mcs_axi_rsp_t rsp;
  mcs_adc_req_t areq;
  mcs_adc_rsp_t arsp;
  int error_cnt, checked;
  logic [31:0] d;
  logic [1:0] r;
  logic [3:0] cnt;
  mcs_measure_scan #(.DWELL_CYCLES(8)) i_mcs_measure_scan (.clk(clk), .rst_n(rst_n),
    .axi_req(req), .axi_rsp(rsp), .adc_req(areq), .adc_rsp(arsp),
    .thermistor_bias_output(bias));
  mcs_adc_model i_mcs_adc_model (.clk(clk), .rst_n(rst_n), .adc_req(areq), .slow(slow),
    .ofs(ofs), .adc_rsp(arsp));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task test_done;
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task cmd(input logic [2:0] op, input logic [5:0] c);
    wr(ADDR_CMD, {12'h000, 4'h3, 2'b00, c, 5'h00, op});
  endtask
  task idle;
    do rd(ADDR_STATUS); while (d[STS_BUSY]);
  endtask
  task ccnt;
    rd(ADDR_SCAN_COUNT);
    cmp(d, 32'(cnt));
  endtask
  initial begin
    #5_000_000;
    error_cnt++;
    test_done;
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    req.wstrb = 4'hf;
    slow = 1'b0;
    ofs = 14'h0;
    error_cnt = 0;
    checked = 0;
    cnt = SCAN_CNT_RST;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    ccnt;
    rd(ADDR_FAULT_SETUP);
    cmp(d, 32'(TCE_RST));
    wr(ADDR_OWN_ADDR, 32'h3);
    for (int c = 0; c < 22; c++) begin
      if (c < 13 || c > 15) begin
        cmd(OP_MEASURE, 6'(c));
        cnt++;
        idle;
        rd(ADDR_RESULT_BASE + 8'(4 * c));
        cmp(d, {20'h0, 6'(c), 6'h00});
        ccnt;
      end
    end
    wr(ADDR_OWN_ADDR, 32'h5);
    cmd(OP_MEASURE, 6'h01);
    idle;
    ccnt;
    wr(ADDR_OWN_ADDR, 32'h3);
    slow <= 1'b1;
    ofs <= 14'h1;
    cmd(OP_MEASURE, 6'h01);
    cmd(OP_MEASURE, 6'h02);
    cnt += 2;
    rd(ADDR_STATUS);
    cmp(32'(d[STS_BUSY]), 32'h1);
    idle;
    rd(ADDR_RESULT_BASE + 8'h04);
    cmp(d, 32'h41);
    rd(ADDR_RESULT_BASE + 8'h08);
    cmp(d, 32'h80);
    ccnt;
    slow <= 1'b0;
    ofs <= 14'h2;
    wr(ADDR_FAULT_SETUP, 32'h5);
    wr(ADDR_THRESH, 32'h4a0);
    cmd(OP_SCAN_TEMPS, 6'h00);
    cnt++;
    cmp(32'(bias), 32'h1);
    idle;
    cmp(32'(bias), 32'h0);
    for (int c = 16; c < 24; c++) begin
      if (c != 22) begin
        rd(ADDR_RESULT_BASE + 8'(4 * c));
        cmp(d, {20'h0, 6'(c), 6'h00} + 32'h2);
      end
    end
    rd(ADDR_STATUS);
    cmp(d, 32'h10);
    ccnt;
    wr(ADDR_INTERVAL, 32'd20);
    cmd(OP_SCAN_CONT, 6'h00);
    cnt++;
    rd(ADDR_STATUS);
    cmp(32'(d[STS_SCAN]), 32'h1);
    repeat (100) @(posedge clk);
    ofs <= 14'h3;
    repeat (100) @(posedge clk);
    rd(8'hdc);
    cmp(d, 32'h5c3);
    cmd(OP_SCAN_INHIBIT, 6'h00);
    idle;
    ofs <= 14'h4;
    repeat (100) @(posedge clk);
    rd(8'hdc);
    cmp(d, 32'h5c3);
    rd(ADDR_STATUS);
    cmp(d & 32'h3, 32'h0);
    ccnt;
    rd(8'h7c);
    cmp(d, 32'h0);
    cmp(32'(r), 32'(RESP_DECERR));
    wr(8'h7c, 32'h1);
    cmp(32'(r), 32'(RESP_DECERR));
    wr(ADDR_SCAN_COUNT, 32'h5);
    ccnt;
    test_done;
  end
endmodule
`default_nettype wire
